// file: pms_pkg.sv
/*
  Shared constants and types of the proximity measurement sequencer.
  Assumes a 200 MHz system clock and an I2C host on the far side.
*/
package pms_pkg;
  localparam logic [7:0] REG_SOFT_RESET  = 8'h01;
  localparam logic [7:0] REG_CFG_FIRST   = 8'h02;
  localparam logic [7:0] REG_INT_CONFIG  = 8'h02;
  localparam logic [7:0] REG_TH_UP_MSB   = 8'h10;
  localparam logic [7:0] REG_TH_UP_LSB   = 8'h11;
  localparam logic [7:0] REG_TH_LO_MSB   = 8'h12;
  localparam logic [7:0] REG_TH_LO_LSB   = 8'h13;
  localparam logic [7:0] REG_MEAS_CTRL   = 8'h17;
  localparam logic [7:0] REG_INT_STATUS  = 8'h40;
  localparam logic [7:0] REG_RESULT_MSB  = 8'h41;
  localparam logic [7:0] REG_RESULT_LSB  = 8'h42;
  localparam logic [7:0] SOFT_RESET_CODE = 8'h01;
  localparam logic [7:0] TH_UP_RESET     = 8'hFF;
  localparam logic [7:0] CFG_RESET       = 8'h00;
  localparam int NUM_CFG          = 22;
  localparam int SINGLE_TRIG_BIT  = 0;
  localparam int REPEAT_MODE_BIT  = 1;
  localparam int INT_LATCH_BIT    = 1;
  localparam int STAT_INT_BIT     = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int OSC_START_NS    = 1000;
  localparam int LED_PHASE_NS    = 2000;
  localparam int WAIT_PERIOD_MS  = 50;
  localparam int WAKE_CYCLES = (OSC_START_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int LED_CYCLES  = (LED_PHASE_NS * 1000 + CLK_PERIOD_PS - 1)
                               / CLK_PERIOD_PS;
  localparam int WAIT_CYCLES_DEF = WAIT_PERIOD_MS * 1000000
                                   / (CLK_PERIOD_PS / 1000);

  typedef enum logic [3:0] {
    I_IDLE, I_ADDR, I_ACK_A, I_REG, I_ACK_R, I_WDATA, I_ACK_W, I_RDATA,
    I_RACK
  } pms_i2c_state_type;

  typedef enum logic [2:0] {
    S_STANDBY, S_WAKE, S_LIT, S_DARK, S_CALC, S_WAIT
  } pms_seq_state_type;

  typedef struct packed {
    logic osc_en;
    logic rx_power;
    logic led_on;
  } pms_afe_ctl_type;
endpackage

// file: pms_sequencer.sv
/*
  I2C register slave and measurement sequencer of a proximity sensor.
  Assumes scl/sda arrive asynchronously from the pins, and that the
  analog front end presents rx_value steady in the clk domain.
*/
`timescale 1ns/1ps
module pms_sequencer #(
  parameter logic [6:0] DEV_ADDR    = 7'h37,
  parameter int         WAIT_CYCLES = pms_pkg::WAIT_CYCLES_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  output logic                           int_out,
  output logic                           int_oe,
  output pms_pkg::pms_afe_ctl_type       afe_ctl,
  input  wire logic [15:0]               rx_value
);
  import pms_pkg::*;

  if (WAIT_CYCLES < 1) begin : g_bad_wait
    $error("WAIT_CYCLES must be at least 1");
  end

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  pms_i2c_state_type i_state_reg, i_next;
  logic [3:0]  bitcnt_reg, bitcnt_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  ptr_reg, ptr_next;
  logic [7:0]  rb_reg, rb_next;
  logic        rw_reg, rw_next;
  logic        nack_reg, nack_next;
  logic        sda_oe_reg, sda_oe_next;
  logic        ctrl_wr_reg, ctrl_wr_next;
  logic        srst_reg, srst_next;
  logic        rclr_reg, rclr_next;
  logic [7:0]  cfg_reg [NUM_CFG];
  logic [7:0]  cfg_next [NUM_CFG];
  pms_seq_state_type st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [15:0] lit_reg, lit_next;
  logic [15:0] amb_reg, amb_next;
  logic [15:0] res_reg, res_next;
  logic        int_reg, int_next;
  logic        done_reg, done_next;
  pms_afe_ctl_type afe_reg;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det, do_load, go;
  logic [15:0] diff, th_up, th_lo;
  logic out_win, latch_mode, repeat_on;

  function automatic logic [4:0] cidx(input logic [7:0] a);
    cidx = 5'(a - REG_CFG_FIRST);
  endfunction

  function automatic logic [7:0] cfg_default(input logic [4:0] i);
    cfg_default = (i == cidx(REG_TH_UP_MSB) || i == cidx(REG_TH_UP_LSB))
                  ? TH_UP_RESET : CFG_RESET;
  endfunction

  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign th_up = {cfg_reg[cidx(REG_TH_UP_MSB)], cfg_reg[cidx(REG_TH_UP_LSB)]};
  assign th_lo = {cfg_reg[cidx(REG_TH_LO_MSB)], cfg_reg[cidx(REG_TH_LO_LSB)]};
  assign latch_mode = cfg_reg[cidx(REG_INT_CONFIG)][INT_LATCH_BIT];
  assign repeat_on  = cfg_reg[cidx(REG_MEAS_CTRL)][REPEAT_MODE_BIT];
  assign diff    = (lit_reg > amb_reg) ? lit_reg - amb_reg : 16'h0000;
  assign out_win = (diff > th_up) || (diff < th_lo);
  // wake only on the STOP that closes a control write
  assign go = stop_det && ctrl_wr_reg &&
              (cfg_reg[cidx(REG_MEAS_CTRL)][SINGLE_TRIG_BIT] || repeat_on);

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    if (a >= REG_CFG_FIRST && a <= REG_MEAS_CTRL) begin
      rd_byte = cfg_reg[cidx(a)];
    end else if (a == REG_INT_STATUS) begin
      rd_byte = 8'(int_reg) << STAT_INT_BIT;
    end else if (a == REG_RESULT_MSB) begin
      rd_byte = res_reg[15:8];
    end else if (a == REG_RESULT_LSB) begin
      rd_byte = res_reg[7:0];
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  // bus slave and register file
  always_comb begin
    logic [7:0] rd;
    rd = rd_byte(ptr_reg);
    i_next = i_state_reg;
    bitcnt_next = bitcnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    rb_next = rb_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    sda_oe_next = sda_oe_reg;
    ctrl_wr_next = ctrl_wr_reg;
    srst_next = 1'b0;
    rclr_next = 1'b0;
    do_load = 1'b0;
    cfg_next = cfg_reg;
    if (done_reg && !repeat_on) begin
      cfg_next[cidx(REG_MEAS_CTRL)][SINGLE_TRIG_BIT] = 1'b0;
    end
    if (scl_rise) begin
      sh_next = {sh_reg[6:0], sda_s};
      bitcnt_next = bitcnt_reg + 4'h1;
      if (i_state_reg == I_RACK) begin
        nack_next = sda_s;
      end
    end
    if (scl_fall) begin
      case (i_state_reg)
        I_ADDR: begin
          if (bitcnt_reg == BYTE_BITS) begin
            if (sh_reg[7:1] == DEV_ADDR) begin
              sda_oe_next = 1'b1;
              rw_next = sh_reg[0];
              i_next = I_ACK_A;
            end else begin
              i_next = I_IDLE;
            end
          end
        end
        I_ACK_A: begin
          if (rw_reg) begin
            do_load = 1'b1;
          end else begin
            sda_oe_next = 1'b0;
            bitcnt_next = 4'h0;
            i_next = I_REG;
          end
        end
        I_REG: begin
          if (bitcnt_reg == BYTE_BITS) begin
            ptr_next = sh_reg;
            sda_oe_next = 1'b1;
            i_next = I_ACK_R;
          end
        end
        I_ACK_R, I_ACK_W: begin
          sda_oe_next = 1'b0;
          bitcnt_next = 4'h0;
          i_next = I_WDATA;
        end
        I_WDATA: begin
          if (bitcnt_reg == BYTE_BITS) begin
            if (ptr_reg == REG_SOFT_RESET && sh_reg == SOFT_RESET_CODE) begin
              srst_next = 1'b1;
            end else if (ptr_reg >= REG_CFG_FIRST &&
                         ptr_reg <= REG_MEAS_CTRL) begin
              cfg_next[cidx(ptr_reg)] = sh_reg;
              if (ptr_reg == REG_MEAS_CTRL) begin
                ctrl_wr_next = 1'b1;
              end
            end
            ptr_next = ptr_reg + 8'h01;
            sda_oe_next = 1'b1;
            i_next = I_ACK_W;
          end
        end
        I_RDATA: begin
          if (bitcnt_reg == BYTE_BITS) begin
            sda_oe_next = 1'b0;
            i_next = I_RACK;
          end else begin
            sda_oe_next = ~rb_reg[7];
            rb_next = {rb_reg[6:0], 1'b0};
          end
        end
        I_RACK: begin
          if (nack_reg) begin
            sda_oe_next = 1'b0;
            i_next = I_IDLE;
          end else begin
            do_load = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (do_load) begin
      sda_oe_next = ~rd[7];
      rb_next = {rd[6:0], 1'b0};
      ptr_next = ptr_reg + 8'h01;
      bitcnt_next = 4'h0;
      i_next = I_RDATA;
      rclr_next = (ptr_reg == REG_INT_STATUS);
    end
    if (start_det) begin
      i_next = I_ADDR;
      bitcnt_next = 4'h0;
      sda_oe_next = 1'b0;
    end
    if (stop_det) begin
      i_next = I_IDLE;
      sda_oe_next = 1'b0;
      ctrl_wr_next = 1'b0;
    end
    if (srst_reg) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_next[i] = cfg_default(5'(i));
      end
    end
  end

  // measurement sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg + 32'h1;
    lit_next = lit_reg;
    amb_next = amb_reg;
    res_next = res_reg;
    int_next = int_reg;
    done_next = 1'b0;
    case (st_reg)
      S_STANDBY: begin
        cnt_next = 32'h0;
        if (go) begin
          st_next = S_WAKE;
        end
      end
      S_WAKE: begin
        if (cnt_reg == 32'(WAKE_CYCLES - 1)) begin
          st_next = S_LIT;
          cnt_next = 32'h0;
        end
      end
      S_LIT: begin
        if (cnt_reg == 32'(LED_CYCLES - 1)) begin
          lit_next = rx_value;
          st_next = S_DARK;
          cnt_next = 32'h0;
        end
      end
      S_DARK: begin
        if (cnt_reg == 32'(LED_CYCLES - 1)) begin
          amb_next = rx_value;
          st_next = S_CALC;
        end
      end
      S_CALC: begin
        res_next = diff;
        done_next = 1'b1;
        int_next = latch_mode ? (int_reg | out_win) : out_win;
        cnt_next = 32'h0;
        st_next = repeat_on ? S_WAIT : S_STANDBY;
      end
      S_WAIT: begin
        if (!repeat_on) begin
          st_next = S_STANDBY;
        end else if (cnt_reg == 32'(WAIT_CYCLES - 1)) begin
          st_next = S_WAKE;
          cnt_next = 32'h0;
        end
      end
      default: st_next = S_STANDBY;
    endcase
    // a new out-of-window result beats a clearing read
    if (rclr_reg && latch_mode && !(st_reg == S_CALC && out_win)) begin
      int_next = 1'b0;
    end
    if (srst_reg) begin
      st_next = S_STANDBY;
      int_next = 1'b0;
      res_next = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i_state_reg <= I_IDLE;
      bitcnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rb_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      ctrl_wr_reg <= 1'b0;
      srst_reg <= 1'b0;
      rclr_reg <= 1'b0;
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_reg[i] <= cfg_default(5'(i));
      end
      st_reg <= S_STANDBY;
      cnt_reg <= 32'h0;
      lit_reg <= 16'h0000;
      amb_reg <= 16'h0000;
      res_reg <= 16'h0000;
      int_reg <= 1'b0;
      done_reg <= 1'b0;
      afe_reg <= '0;
    end else begin
      i_state_reg <= i_next;
      bitcnt_reg <= bitcnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      rb_reg <= rb_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      sda_oe_reg <= sda_oe_next;
      ctrl_wr_reg <= ctrl_wr_next;
      srst_reg <= srst_next;
      rclr_reg <= rclr_next;
      cfg_reg <= cfg_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      lit_reg <= lit_next;
      amb_reg <= amb_next;
      res_reg <= res_next;
      int_reg <= int_next;
      done_reg <= done_next;
      // powered only while a cycle runs
      afe_reg.osc_en <= st_next inside {S_WAKE, S_LIT, S_DARK, S_CALC};
      afe_reg.rx_power <= st_next inside {S_WAKE, S_LIT, S_DARK, S_CALC};
      afe_reg.led_on <= (st_next == S_LIT);
    end
  end

  assign sda_out = 1'b0;
  assign int_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  assign int_oe  = int_reg;
  assign afe_ctl = afe_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_leave_standby;
    st_reg == S_STANDBY ##1 st_reg == S_WAKE;
  endsequence
  property p_wake_on_stop;
    s_leave_standby |-> $past(stop_det) && $past(ctrl_wr_reg);
  endproperty
  a_wake_on_stop: assert property (p_wake_on_stop)
    else $error("cycle started without a closing stop");
  property p_single_clear;
    (st_reg == S_CALC && !repeat_on && !srst_reg) |=> ##1
      !cfg_reg[cidx(REG_MEAS_CTRL)][SINGLE_TRIG_BIT];
  endproperty
  a_single_clear: assert property (p_single_clear)
    else $error("single trigger bit not cleared");
  property p_repeat_wait;
    (st_reg == S_CALC && repeat_on && !srst_reg) |=> st_reg == S_WAIT;
  endproperty
  a_repeat_wait: assert property (p_repeat_wait)
    else $error("repeat mode did not re-arm");
  property p_power_off;
    st_reg inside {S_STANDBY, S_WAIT} |-> afe_reg == '0;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("front end powered outside a cycle");
  property p_led_after_wake;
    $rose(afe_reg.led_on) |-> $past(st_reg) == S_WAKE && afe_reg.osc_en;
  endproperty
  a_led_after_wake: assert property (p_led_after_wake)
    else $error("led started before wake-up");
  property p_result;
    (st_reg == S_CALC && !srst_reg) |=> res_reg == $past(diff);
  endproperty
  a_result: assert property (p_result)
    else $error("result is not lit minus ambient");
  property p_int_set;
    (st_reg == S_CALC && out_win && !srst_reg) |=> int_oe;
  endproperty
  a_int_set: assert property (p_int_set)
    else $error("out-of-window result raised no interrupt");
  property p_read_clear;
    (rclr_reg && latch_mode && st_reg != S_CALC) |=> !int_oe;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear interrupt");
  property p_soft_reset;
    srst_reg |=> st_reg == S_STANDBY && cfg_reg[cidx(REG_MEAS_CTRL)] == 8'h00;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left state behind");
  property p_ptr_inc;
    (i_state_reg == I_WDATA && scl_fall && bitcnt_reg == BYTE_BITS &&
     !start_det && !stop_det) |=> ptr_reg == $past(ptr_reg) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer not advanced on ack");
endmodule

// file: pms_host.sv
/*
  I2C host model for the proximity sequencer: bit-level master, 125 ns SCL.
  Assumes the bench resolves SDA with a pull-up from both pull-down enables.
*/
`timescale 1ns/1ps
module pms_host #(
  parameter logic [6:0] DEV_ADDR = 7'h37
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // 13 low + 12 high periods; sda only moves mid-low, never near an edge
  task automatic put_bit(input logic b, output logic s);
    wt(6);
    sda_oe = ~b;
    wt(7);
    scl = 1'b1;
    wt(6);
    s = sda;
    wt(6);
    scl = 1'b0;
  endtask

  // also serves as repeated start, since scl is low between bytes
  task automatic send_start();
    wt(6);
    sda_oe = 1'b0;
    wt(7);
    scl = 1'b1;
    wt(6);
    sda_oe = 1'b1;
    wt(6);
    scl = 1'b0;
  endtask

  task automatic send_stop();
    wt(6);
    sda_oe = 1'b1;
    wt(7);
    scl = 1'b1;
    wt(6);
    sda_oe = 1'b0;
    wt(12);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      b[i] = s;
    end
    put_bit(nack, s);
  endtask

  task automatic write_reg(input logic [7:0] r, input logic [7:0] v,
                           output logic ok);
    logic a0, a1, a2;
    send_start();
    send_byte({DEV_ADDR, 1'b0}, a0);
    send_byte(r, a1);
    send_byte(v, a2);
    send_stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] r, output logic [7:0] v);
    logic a;
    send_start();
    send_byte({DEV_ADDR, 1'b0}, a);
    send_byte(r, a);
    send_start();
    send_byte({DEV_ADDR, 1'b1}, a);
    recv_byte(1'b1, v);
    send_stop();
  endtask
endmodule

// file: testbench.sv
/*
  Self-checking bench of the proximity sequencer over its I2C port.
  Assumes pms_pkg and pms_host; a stub front end gives lit/ambient values.
*/
`timescale 1ns/1ps
module testbench;
  import pms_pkg::*;
  localparam int WAIT_N = 50;
  localparam int LIMIT  = 90000;
  logic            clk, rst_n, scl, host_oe, dev_oe, int_oe, sda, ack;
  logic [15:0]     rx_value, lit_val, amb_val;
  logic [7:0]      rd;
  logic            sda_o, int_o;
  logic [7:0]      blk [4];
  logic            osc_d;
  pms_afe_ctl_type afe_ctl;
  int              error_cnt, checked, cycles, osc_rises, n0;

  // open-drain wire with pull-up
  assign sda = ~(host_oe | dev_oe);

  pms_sequencer #(.DEV_ADDR(7'h37), .WAIT_CYCLES(WAIT_N)) i_pms_sequencer (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(dev_oe), .int_out(int_o), .int_oe(int_oe), .afe_ctl(afe_ctl),
    .rx_value(rx_value));

  pms_host #(.DEV_ADDR(7'h37)) i_pms_host (
    .clk(clk), .sda(sda), .scl(scl), .sda_oe(host_oe));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(negedge clk) rx_value <= afe_ctl.led_on ? lit_val : amb_val;

  always @(posedge clk) begin
    osc_d <= afe_ctl.osc_en;
    if (afe_ctl.osc_en && !osc_d) osc_rises <= osc_rises + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] r, input logic [7:0] exp);
    i_pms_host.read_reg(r, rd);
    check({8'h00, rd}, {8'h00, exp});
  endtask

  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    i_pms_host.write_reg(r, v, ack);
    check({15'h0000, ack}, 16'h0001);
  endtask

  task automatic wait_afe(input logic [2:0] exp, input int lim);
    int n;
    n = 0;
    while (afe_ctl !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    check({13'h0000, afe_ctl}, {13'h0000, exp});
  endtask

  // no front-end activity may appear before the closing stop
  task automatic shot(input logic [7:0] ctl);
    i_pms_host.send_start();
    i_pms_host.send_byte({7'h37, 1'b0}, ack);
    i_pms_host.send_byte(REG_MEAS_CTRL, ack);
    i_pms_host.send_byte(ctl, ack);
    repeat (30) @(negedge clk);
    check({13'h0000, afe_ctl}, 16'h0000);
    i_pms_host.send_stop();
    wait_afe(3'h6, 20);
    wait_afe(3'h7, 300);
    wait_afe(3'h0, 1000);
  endtask

  task automatic conclude();
    $display("counts: checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    lit_val = 16'h0123;
    amb_val = 16'h0020;
    rx_value = 16'h0000;
    osc_d = 1'b0;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    osc_rises = 0;
    blk = '{8'h00, 8'h10, 8'h00, 8'h05};
    repeat (5) @(negedge clk);
    check({9'h000, sda_o, int_o, dev_oe, int_oe, afe_ctl}, 16'h0000);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    rd_chk(REG_MEAS_CTRL, 8'h00);
    rd_chk(REG_TH_UP_MSB, TH_UP_RESET);
    rd_chk(REG_INT_STATUS, 8'h00);
    rd_chk(8'h30, 8'h00);
    $display("test reset_values done");
    i_pms_host.send_start();
    i_pms_host.send_byte({7'h37, 1'b0}, ack);
    i_pms_host.send_byte(REG_TH_UP_MSB, ack);
    foreach (blk[i]) begin
      i_pms_host.send_byte(blk[i], ack);
      check({15'h0000, ack}, 16'h0001);
    end
    i_pms_host.send_stop();
    foreach (blk[i]) rd_chk(8'(REG_TH_UP_MSB + i), blk[i]);
    $display("test block_write done");
    shot(8'h01);
    rd_chk(REG_MEAS_CTRL, 8'h00);
    rd_chk(REG_RESULT_MSB, 8'h01);
    rd_chk(REG_RESULT_LSB, 8'h03);
    check({15'h0000, int_oe}, 16'h0001);
    rd_chk(REG_INT_STATUS, 8'h10);
    rd_chk(REG_INT_STATUS, 8'h10);
    $display("test single_shot done");
    wr(REG_INT_CONFIG, 8'h02);
    shot(8'h01);
    lit_val = 16'h0008;
    amb_val = 16'h0000;
    shot(8'h01);
    check({15'h0000, int_oe}, 16'h0001);
    rd_chk(REG_INT_STATUS, 8'h10);
    check({15'h0000, int_oe}, 16'h0000);
    rd_chk(REG_INT_STATUS, 8'h00);
    $display("test latch_clear done");
    lit_val = 16'h0123;
    n0 = osc_rises;
    shot(8'h02);
    rd_chk(REG_MEAS_CTRL, 8'h02);
    for (int i = 0; i < 6000 && osc_rises < n0 + 3; i++) @(negedge clk);
    check(16'(osc_rises - n0), 16'h0003);
    wr(REG_MEAS_CTRL, 8'h00);
    repeat (1500) @(negedge clk);
    n0 = osc_rises;
    repeat (1500) @(negedge clk);
    check(16'(osc_rises - n0), 16'h0000);
    check({13'h0000, afe_ctl}, 16'h0000);
    $display("test repeat_mode done");
    wr(REG_TH_UP_MSB, 8'h33);
    wr(REG_SOFT_RESET, 8'h02);
    rd_chk(REG_TH_UP_MSB, 8'h33);
    wr(REG_MEAS_CTRL, 8'h02);
    wr(REG_SOFT_RESET, SOFT_RESET_CODE);
    check({12'h000, int_oe, afe_ctl}, 16'h0000);
    rd_chk(REG_MEAS_CTRL, 8'h00);
    rd_chk(REG_TH_UP_MSB, TH_UP_RESET);
    rd_chk(REG_INT_CONFIG, CFG_RESET);
    $display("test soft_reset done");
    conclude();
  end
endmodule
